// file: hw/tsoc_tx_out.sv
// Transmit stream output stage with rate select and enable indication.
//
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
// Offsets, field positions and counts come from the shared header.
`include "tsoc_cfg.svh"
module tsoc_tx_out
	import tsoc_pkg::*;
#(
	parameter int NUM_GRP = 8
)(
	input  wire logic                 core_clk_i,
	input  wire logic                 sys_rst_i,
	input  wire logic [3:0]           avs_address_i,
	input  wire logic                 avs_read_i,
	input  wire logic                 avs_write_i,
	input  wire logic [31:0]          avs_writedata_i,
	input  wire logic [3:0]           avs_byteenable_i,
	output logic      [31:0]          avs_readdata_o,
	output logic                      avs_waitrequest_o,
	input  wire logic                 output_drive_enable_pin_i,
	input  wire logic [NUM_GRP*8-1:0] tx_data_i,
	input  wire logic [NUM_GRP*24-1:0] channel_mode_field_i,
	output logic      [NUM_GRP*8-1:0] tx_data_o,
	output logic      [NUM_GRP*8-1:0] tx_oe_o
);
	localparam int NS = NUM_GRP * 8;
	localparam int NP = NUM_GRP / 2;
	localparam int RW = NUM_GRP * `TSOC_RATE_W;

	// ----------------------------------------
	// Elaboration check
	// ----------------------------------------
	// Pairs of groups and the 32-bit rate word limit the group count.
	if (NUM_GRP != 2 && NUM_GRP != 4 && NUM_GRP != 8) begin : g_bad
		$error("NUM_GRP must be 2, 4 or 8.");
	end

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// Clocks per bit minus one, as a mask over the bit divider.
	function automatic logic [`TSOC_DIV_W-1:0] rate_mask(input logic [2:0] code);
		case (code)
			TSOC_R2M:  rate_mask = 4'hf;
			TSOC_R4M:  rate_mask = 4'h7;
			TSOC_R8M:  rate_mask = 4'h3;
			TSOC_R16M: rate_mask = 4'h1;
			default:   rate_mask = 4'h0;
		endcase
	endfunction

	// Codes above the top rate are not served and keep the group floating unless it carries indication pins.
	function automatic logic rate_ok(input logic [2:0] code);
		rate_ok = (code <= TSOC_R32M);
	endfunction

	function automatic logic [31:0] be_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		be_merge = r;
	endfunction

	// ----------------------------------------
	// Registers and bus slave
	// ----------------------------------------
	logic [RW-1:0]         rate_ff;
	logic [4:0]            ctrl_ff;
	tsoc_bus_t             bus_ff;
	logic [31:0]           avs_readdata_ff;
	logic [`TSOC_DIV_W-1:0] div_cnt_ff;
	logic [NS-1:0]         tx_data_ff;
	logic [NS-1:0]         tx_oe_ff;
	logic [NS-1:0]         nxt_tx_data;
	logic [NS-1:0]         nxt_tx_oe;
	logic [NS-1:0]         stream_oe;
	logic [NUM_GRP-1:0]    bit_stb;
	logic [NUM_GRP-1:0]    grp_unavail;
	logic [NUM_GRP-1:0]    grp_drive;
	logic [NP-1:0]         ind_sel;
	logic [NP-1:0]         pair_unavail;
	// Waitrequest sits in its own flop so the pin comes straight from a register.
	logic                  avs_wait_ff;

	wire        bus_req  = avs_read_i | avs_write_i;
	wire        bus_take = bus_req & (bus_ff == TSOC_BUS_ANS);
	wire        hit_rate = (avs_address_i == `TSOC_OFS_RATE);
	wire        hit_ctrl = (avs_address_i == `TSOC_OFS_CTRL);
	wire        hit_stat = (avs_address_i == `TSOC_OFS_STAT);
	wire        output_standby_bit = ctrl_ff[`TSOC_CTRL_STANDBY];
	wire        drive_on = output_drive_enable_pin_i | output_standby_bit;
	wire [31:0] rate_word = 32'(rate_ff);
	wire [31:0] ctrl_word = {27'h0, ctrl_ff};
	wire [31:0] stat_word = {16'h0, 8'(grp_drive), 4'(ind_sel), 4'(pair_unavail)};
	wire [31:0] rd_mux = hit_rate ? rate_word :
		hit_ctrl ? ctrl_word : hit_stat ? stat_word : 32'h0;
	wire [31:0] rate_wr = be_merge(rate_word, avs_writedata_i, avs_byteenable_i);
	wire [31:0] ctrl_wr = be_merge(ctrl_word, avs_writedata_i, avs_byteenable_i);
	wire        wr_rate = bus_take & avs_write_i & hit_rate;
	wire        wr_ctrl = bus_take & avs_write_i & hit_ctrl;
	wire        rd_take = (bus_ff == TSOC_BUS_IDLE) & avs_read_i;

	assign ind_sel = ctrl_ff[`TSOC_CTRL_IND +: NP];

	// ----------------------------------------
	// Status word
	// ----------------------------------------
	// Only odd groups can be lost, so status keeps one bit per pair.
	for (genvar p = 0; p < NP; p++) begin : g_pair
		assign pair_unavail[p] = grp_unavail[2*p+1];
	end

	// One cycle of wait, then the answer stands for the single accepting edge.
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			bus_ff <= TSOC_BUS_IDLE;
			avs_wait_ff <= 1'b1;
		end else if (bus_take) begin
			bus_ff <= TSOC_BUS_IDLE;
			avs_wait_ff <= 1'b1;
		end else if (bus_req) begin
			bus_ff <= TSOC_BUS_ANS;
			avs_wait_ff <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			rate_ff <= `TSOC_RATE_RST;
			ctrl_ff <= `TSOC_CTRL_RST;
		end else begin
			if (wr_rate) begin
				rate_ff <= rate_wr[RW-1:0];
			end
			if (wr_ctrl) begin
				ctrl_ff <= ctrl_wr[4:0];
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			avs_readdata_ff <= 32'h0;
		end else if (rd_take) begin
			avs_readdata_ff <= rd_mux;
		end else begin
			avs_readdata_ff <= 32'h0;
		end
	end

	// ----------------------------------------
	// Bit divider
	// ----------------------------------------
	// One shared divider keeps all groups bit-aligned to the frame.
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			div_cnt_ff <= '0;
		end else begin
			div_cnt_ff <= div_cnt_ff + 4'h1;
		end
	end

	// ----------------------------------------
	// Per-group and per-stream output logic
	// ----------------------------------------
	for (genvar g = 0; g < NUM_GRP; g++) begin : g_grp
		wire [2:0] code = rate_ff[g*3 +: 3];
		assign bit_stb[g] = ((div_cnt_ff & rate_mask(code)) == 4'h0);
		if (g % 2 == 1) begin : g_odd
			assign grp_unavail[g] = (rate_ff[(g-1)*3 +: 3] == TSOC_R32M);
		end else begin : g_even
			assign grp_unavail[g] = 1'b0;
		end
		assign grp_drive[g] = |stream_oe[g*8 +: 8];
		for (genvar c = 0; c < 8; c++) begin : g_str
			localparam int S = g * 8 + c;
			wire hiz = (channel_mode_field_i[S*3 +: 3] == `TSOC_HIZ_MODE);
			// Whole group shares rate, unavailability and validity.
			assign stream_oe[S] = drive_on & ~hiz & ~grp_unavail[g] & rate_ok(code);
			if (g % 2 == 1) begin : g_share
				wire ind = ind_sel[g/2];
				// Indication pins stay driven; they report whether the paired stream is driven.
				assign nxt_tx_oe[S] = ind | stream_oe[S];
				assign nxt_tx_data[S] = ind ? stream_oe[S-8] :
					bit_stb[g] ? tx_data_i[S] : tx_data_ff[S];
			end else begin : g_plain
				assign nxt_tx_oe[S] = stream_oe[S];
				assign nxt_tx_data[S] = bit_stb[g] ? tx_data_i[S] : tx_data_ff[S];
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			tx_data_ff <= '0;
			tx_oe_ff <= '0;
		end else begin
			tx_data_ff <= nxt_tx_data;
			tx_oe_ff <= nxt_tx_oe;
		end
	end

	assign tx_data_o = tx_data_ff;
	assign tx_oe_o = tx_oe_ff;
	assign avs_readdata_o = avs_readdata_ff;
	assign avs_waitrequest_o = avs_wait_ff;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	// Reset is held three clocks, so its effect is checked after every reset edge.
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);

	// This one must see reset itself, so it opts out of the default disable.
	reset_floats_a: assert property (@(posedge core_clk_i) disable iff (1'b0)
		sys_rst_i |=> (tx_oe_o == '0) && (tx_data_o == '0)
			&& (avs_readdata_o == 32'h0) && avs_waitrequest_o)
		else $error("Outputs not floated by reset.");

	odd_blocked_a: assert property (
		(rate_ff[2:0] == TSOC_R32M) && !ind_sel[0] |=> (tx_oe_o[15:8] == 8'h0))
		else $error("Odd group driven beside a top-rate even group.");

	standby_hiz_a: assert property (
		!output_drive_enable_pin_i && !output_standby_bit |=> (tx_oe_o[7:0] == 8'h0))
		else $error("Stream driven while drive is off.");

	chan_hiz_a: assert property (
		(channel_mode_field_i[2:0] == 3'h7) |=> !tx_oe_o[0])
		else $error("High-impedance channel still driven.");

	ind_shows_a: assert property (
		ind_sel[0] |=> tx_oe_o[8] && (tx_data_o[8] == tx_oe_o[0]))
		else $error("Indication pin disagrees with paired stream.");

	shared_data_a: assert property (
		!ind_sel[0] && (rate_ff[5:3] == TSOC_R32M) |=> tx_data_o[8] == $past(tx_data_i[8]))
		else $error("Shared pin lost its stream data.");

	top_rate_a: assert property (
		(rate_ff[2:0] == TSOC_R32M) |=> tx_data_o[0] == $past(tx_data_i[0]))
		else $error("Top-rate stream missed a bit.");

	group_hold_a: assert property (
		(rate_ff[2:0] == TSOC_R2M) && (div_cnt_ff != 4'h0) |=> $stable(tx_data_o[7:0]))
		else $error("Slow group changed between bit edges.");

	bus_answer_a: assert property (
		bus_req && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("Bus request not answered in one cycle.");

	bad_rate_a: assert property (
		!rate_ok(rate_ff[2:0]) |=> (tx_oe_o[7:0] == 8'h0))
		else $error("Group with an unserved rate code still driven.");

	drive_on_a: assert property (
		drive_on && (channel_mode_field_i[2:0] != `TSOC_HIZ_MODE) && rate_ok(rate_ff[2:0])
			|=> tx_oe_o[0])
		else $error("Enabled stream not driven.");

	hiz_only_a: assert property (
		drive_on && (channel_mode_field_i[2:0] == `TSOC_HIZ_MODE) && rate_ok(rate_ff[2:0])
			&& (channel_mode_field_i[5:3] != `TSOC_HIZ_MODE) |=> tx_oe_o[1])
		else $error("Floating channel took its neighbour along.");

	ind_driven_a: assert property (
		ind_sel[NP-1] |=> (tx_oe_o[NS-1 -: 8] == 8'hff))
		else $error("Indication pins not driven.");

	// The master may raise its next request only after the accepting edge.
	wait_one_a: assert property (
		!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("Waitrequest low for more than one cycle.");

	read_idle_a: assert property (
		avs_waitrequest_o |-> (avs_readdata_o == 32'h0))
		else $error("Read data outside the answer cycle.");

	// ----------------------------------------
	// Cover points
	// ----------------------------------------
	rate_write_c: cover property (wr_rate);
	ind_mode_c: cover property (ind_sel[0] && tx_oe_o[0]);
	stat_read_c: cover property (rd_take && hit_stat);
	blocked_c: cover property (grp_unavail[1] && stream_oe[0]);
	hiz_chan_c: cover property (drive_on && !stream_oe[0] && stream_oe[1]);
endmodule
`default_nettype wire

// file: hw/tsoc_cfg.svh
// Offsets, field positions, reset values and timing counts of the output stage.
`ifndef TSOC_CFG_SVH
`define TSOC_CFG_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TSOC_OFS_RATE    4'h0
`define TSOC_OFS_CTRL    4'h4
`define TSOC_OFS_STAT    4'h8
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define TSOC_CTRL_STANDBY 0
`define TSOC_CTRL_IND     1
`define TSOC_RATE_RST    24'h000000
`define TSOC_CTRL_RST    5'h00
`define TSOC_RATE_W      3
`define TSOC_HIZ_MODE    3'h7
// ----------------------------------------
// Timing
// ----------------------------------------
`define TSOC_CLK_NS      8
`define TSOC_RST_MIN_NS  20
`define TSOC_RST_CYC     ((`TSOC_RST_MIN_NS + `TSOC_CLK_NS - 1) / `TSOC_CLK_NS)
`define TSOC_DIV_W       4
`endif

// file: hw/tsoc_pkg.sv
// Types shared by the transmit stream output stage.
package tsoc_pkg;
	typedef enum logic [2:0] {
		TSOC_R2M  = 3'h0,
		TSOC_R4M  = 3'h1,
		TSOC_R8M  = 3'h2,
		TSOC_R16M = 3'h3,
		TSOC_R32M = 3'h4
	} tsoc_rate_t;
	typedef enum logic {
		TSOC_BUS_IDLE = 1'b0,
		TSOC_BUS_ANS  = 1'b1
	} tsoc_bus_t;
endpackage

// file: verif/tsoc_line_model.sv
// Line model of the downstream serial receivers on the transmit pins.
`timescale 1ns/1ns
`default_nettype none
module tsoc_line_model (
	input  wire logic        core_clk_i,
	input  wire logic [63:0] tx_data_i,
	input  wire logic [63:0] tx_oe_i,
	output logic      [63:0] line_o
);
	// ---
	// Line level
	// ---
	// No pull on these lines, so a floating line toggles to keep stale data from matching.
	logic [63:0] last_ff = 64'h0;
	always_ff @(posedge core_clk_i) begin
		last_ff <= line_o;
	end
	assign line_o = (tx_oe_i & tx_data_i) | (~tx_oe_i & ~last_ff);
endmodule
`default_nettype wire

// file: verif/tx_stream_output_control_tb_top.sv
// Self-checking bench of the transmit stream output stage.
`timescale 1ns/1ns
`default_nettype none
module tx_stream_output_control_tb_top import tsoc_pkg::*;;
	logic         clk = 0, rst = 1, rd = 0, wr = 0, pin = 0;
	logic [3:0]   adr = 0, be = 0;
	logic [31:0]  wdat = 0, q, seed = 32'd78684;
	logic [63:0]  txi = 0, txo, oe, line, e, d;
	logic [191:0] mode = 0, m;
	logic [23:0]  rate_m = 0, r;
	logic [4:0]   ctrl_m = 0;
	logic [3:0]   bsel = 4'hf;
	logic [7:0]   prv [8];
	logic [31:0]  rdat;
	logic         wreq;
	int           fails = 0, checks_done = 0, cyc = 0, last [8];
	tsoc_tx_out #(.NUM_GRP(8)) dut (.core_clk_i(clk), .sys_rst_i(rst), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .output_drive_enable_pin_i(pin),
		.tx_data_i(txi), .channel_mode_field_i(mode), .tx_data_o(txo), .tx_oe_o(oe));
	tsoc_line_model lm (.core_clk_i(clk), .tx_data_i(txo), .tx_oe_i(oe), .line_o(line));
	// ---
	// Helpers
	// ---
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc > 5000) begin
			fails++;
			results();
		end
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic results();
		if (fails == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] dv);
		@(posedge clk);
		adr <= a;
		wdat <= dv;
		be <= bsel;
		wr <= w;
		rd <= !w;
		do @(posedge clk); while (wreq !== 1'b0);
		q = rdat;
		rd <= 0;
		wr <= 0;
	endtask
	task automatic wreg(input logic [3:0] a, input logic [31:0] dv);
		bus(1, a, dv);
		if (a == 4'h0) rate_m = dv[23:0];
		if (a == 4'h4) ctrl_m = dv[4:0];
	endtask
	task automatic expect_out();
		e = 0;
		d = txi;
		for (int s = 0; s < 64; s++) begin
			e[s] = (rate_m[3*(s/8)+:3] <= 3'h4) && (pin || ctrl_m[0]) && (mode[3*s+:3] != 3'h7);
			if ((s/8) % 2 == 1 && rate_m[3*(s/8-1)+:3] == TSOC_R32M) e[s] = 1'b0;
		end
		for (int s = 8; s < 64; s++) if ((s/8) % 2 == 1 && ctrl_m[1+s/16]) begin
			d[s] = e[s-8];
			e[s] = 1'b1;
		end
	endtask
	task automatic settle_chk();
		repeat (18) @(posedge clk);
		expect_out();
		#1;
		chk(oe, e);
		chk(line & e, d & e);
	endtask
	task automatic do_reset();
		if (cyc > 0) @(posedge clk);
		rst <= 1;
		pin <= 1;
		txi <= '1;
		repeat (3) @(posedge clk);
		rst <= 0;
		rate_m = 0;
		ctrl_m = 0;
		#1;
		chk(oe, 0);
		chk(txo, 0);
		chk({wreq, rdat}, 64'h100000000);
		bus(0, 4'h0, 0);
		chk(q, 0);
		bus(0, 4'h4, 0);
		chk(q, 0);
	endtask
	// ---
	// Scenarios
	// ---
	initial begin
		do_reset();
		wreg(4'h0, 32'h4688);
		settle_chk();
		wreg(4'h8, 32'hffffffff);
		bus(0, 4'h8, 0);
		chk(q, 32'hdf04);
		bus(0, 4'hc, 0);
		chk(q, 0);
		for (int g = 0; g < 8; g++) begin
			last[g] = -1;
			prv[g] = txo[8*g+:8];
		end
		for (int k = 0; k < 64; k++) begin
			@(posedge clk);
			txi <= {rnd(), rnd()};
			#1;
			for (int g = 0; g < 5; g++) if (txo[8*g+:8] !== prv[g]) begin
				if (last[g] >= 0) chk((k - last[g]) % (16 >> g), 0);
				last[g] = k;
				prv[g] = txo[8*g+:8];
			end
		end
		bsel = 4'h1;
		bus(1, 4'h0, 32'hffffff00);
		bsel = 4'hf;
		bus(0, 4'h0, 0);
		chk(q, 32'h4600);
		rate_m = 24'h004600;
		// The first two passes pin the drive corners: all floating, then standby driving.
		for (int k = 0; k < 12; k++) begin
			for (int g = 0; g < 8; g++) r[3*g+:3] = 3'(rnd() % 6);
			for (int s = 0; s < 64; s++) m[3*s+:3] = (rnd() % 4 == 0) ? 3'h7 : 3'(rnd() % 7);
			wreg(4'h0, {8'h00, r});
			wreg(4'h4, 32'((k < 2) ? k : rnd() % 32));
			mode <= m;
			txi <= {rnd(), rnd()};
			pin <= (k < 2) ? 1'b0 : rnd() % 2;
			settle_chk();
			bus(0, 4'h0, 0);
			chk(q, {8'h00, rate_m});
			bus(0, 4'h4, 0);
			chk(q, ctrl_m);
		end
		do_reset();
		results();
	end
endmodule
`default_nettype wire
